// ===== tmr_pkg.sv
// ****************************************************************
// Shared constants for the dual timer/counter
// ****************************************************************
package tmr_pkg;

  // Count width arrangement of one channel
  typedef enum logic [1:0] {
    MODE_PRESCALE,                        // High byte behind a 5-bit prescaler
    MODE_WIDE,                            // Full 16-bit cascade
    MODE_RELOAD,                          // Low byte with reload from high byte
    MODE_SPLIT                            // Two separate bytes / channel stop
  } tmr_mode_t;

  // Register addresses on the core's special function register port
  localparam logic [7:0] ADDR_CONTROL  = 8'h88;  // timer_control_flags
  localparam logic [7:0] ADDR_MODE     = 8'h89;  // timer_mode_select
  localparam logic [7:0] ADDR_CNT0_LO  = 8'h8a;  // Channel 0 count_low_byte
  localparam logic [7:0] ADDR_CNT1_LO  = 8'h8b;  // Channel 1 count_low_byte
  localparam logic [7:0] ADDR_CNT0_HI  = 8'h8c;  // Channel 0 count_high_byte
  localparam logic [7:0] ADDR_CNT1_HI  = 8'h8d;  // Channel 1 count_high_byte

  // Reset values
  localparam logic [7:0] CONTROL_RESET = 8'h00;
  localparam logic [7:0] MODE_RESET    = 8'h00;
  localparam logic [7:0] COUNT_RESET   = 8'h00;

  // Field layout of timer_mode_select: one nibble per channel
  localparam int TIMER_MODE_SELECT_NIB_W    = 4;       // Channel n starts at bit n*4
  localparam int TIMER_MODE_SELECT_MODE_LSB = 0;       // mode_field_low, mode_field_high above
  localparam int TIMER_MODE_SELECT_CT_BIT   = 2;       // Counter (1) or timer (0)
  localparam int TIMER_MODE_SELECT_GATE_BIT = 3;       // External gating

  // Field layout of timer_control_flags, indexed by channel
  localparam int TIMER_CONTROL_FLAGS_TF[2] = '{5, 7};    // Overflow flags
  localparam int TIMER_CONTROL_FLAGS_TR[2] = '{4, 6};    // Run bits
  localparam int TIMER_CONTROL_FLAGS_IE[2] = '{1, 3};    // External interrupt flags
  localparam int TIMER_CONTROL_FLAGS_IT[2] = '{0, 2};    // External interrupt type bits

  // Count limits
  localparam logic [4:0]  PRE_MAX  = 5'h1f;     // Prescaler terminal count
  localparam logic [7:0]  BYTE_MAX = 8'hff;     // Byte terminal count
  localparam logic [15:0] WIDE_MAX = 16'hffff;  // Cascade terminal count

endpackage : tmr_pkg

// ===== tmr_chan_if.sv
`timescale 1ns/1ps
// ****************************************************************
// Control and count signals between the top and one channel
// ****************************************************************
interface tmr_chan_if;
  tmr_pkg::tmr_mode_t mode;       // Selected count arrangement
  logic               inc;        // Count event for the main counter
  logic               inc_split;  // Count event for the split high byte
  logic               wr_lo;      // Software load of the low byte
  logic               wr_hi;      // Software load of the high byte
  logic [7:0]         wdata;      // Load value
  logic [7:0]         lo;         // Low byte contents
  logic [7:0]         hi;         // High byte contents
  logic               ovf;        // Main counter rollover pulse
  logic               ovf_split;  // Split high byte rollover pulse

  modport ctl  (output mode, inc, inc_split, wr_lo, wr_hi, wdata,
                input  lo, hi, ovf, ovf_split);
  modport chan (input  mode, inc, inc_split, wr_lo, wr_hi, wdata,
                output lo, hi, ovf, ovf_split);
endinterface : tmr_chan_if

// ===== tmr_edge_smp.sv
`timescale 1ns/1ps
// ****************************************************************
// Machine-cycle sampler with falling-edge detect
// ****************************************************************
module tmr_edge_smp (
  input  wire logic clk,     // Oscillator clock
  input  wire logic rst_b,   // Asynchronous reset, active low
  input  wire logic stb,     // Machine-cycle strobe
  input  wire logic pin,     // Pin level, synchronous to clk
  output logic      smp,     // Latest machine-cycle sample
  output logic      fall     // High then low seen, held for one machine cycle
);
  logic prev;                // Sample of the previous machine cycle

  // One sample per machine cycle; idle level is high
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      prev <= 1'b1;
      smp  <= 1'b1;
    end else if (stb) begin
      prev <= smp;
      smp  <= pin;
    end
  end

  // Stays up until the next strobe, which is where the count lands
  assign fall = prev & ~smp;
endmodule // tmr_edge_smp

// ===== tmr_chan.sv
`timescale 1ns/1ps
// ****************************************************************
// One timer/counter channel: low and high count bytes
// ****************************************************************
module tmr_chan (
  input  wire logic clk,     // Oscillator clock
  input  wire logic rst_b,   // Asynchronous reset, active low
  tmr_chan_if.chan  bus      // Control from the top
);
  import tmr_pkg::*;
  logic [7:0] next_lo;       // Low byte after this cycle
  logic [7:0] next_hi;       // High byte after this cycle

  // Count arrangement per mode; a software load overrides the count
  always_comb begin
    next_lo       = bus.lo;
    next_hi       = bus.hi;
    bus.ovf       = 1'b0;
    bus.ovf_split = 1'b0;
    unique case (bus.mode)
      MODE_PRESCALE: begin
        // Upper three low-byte bits are left as they are
        if (bus.inc) begin
          next_lo[4:0] = bus.lo[4:0] + 5'h01;
          if (bus.lo[4:0] == PRE_MAX) begin
            next_hi = bus.hi + 8'h01;
            bus.ovf = (bus.hi == BYTE_MAX);
          end
        end
      end
      MODE_WIDE: begin
        if (bus.inc) begin
          {next_hi, next_lo} = {bus.hi, bus.lo} + 16'h0001;
          bus.ovf            = ({bus.hi, bus.lo} == WIDE_MAX);
        end
      end
      MODE_RELOAD: begin
        // Reload never touches the high byte
        if (bus.inc) begin
          if (bus.lo == BYTE_MAX) begin
            next_lo = bus.hi;
            bus.ovf = 1'b1;
          end else begin
            next_lo = bus.lo + 8'h01;
          end
        end
      end
      MODE_SPLIT: begin
        if (bus.inc) begin
          next_lo = bus.lo + 8'h01;
          bus.ovf = (bus.lo == BYTE_MAX);
        end
        if (bus.inc_split) begin
          next_hi       = bus.hi + 8'h01;
          bus.ovf_split = (bus.hi == BYTE_MAX);
        end
      end
    endcase
    if (bus.wr_lo) begin
      next_lo = bus.wdata;
    end
    if (bus.wr_hi) begin
      next_hi = bus.wdata;
    end
  end

  // Count bytes
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bus.lo <= COUNT_RESET;
      bus.hi <= COUNT_RESET;
    end else begin
      bus.lo <= next_lo;
      bus.hi <= next_hi;
    end
  end
endmodule // tmr_chan

// ===== tmr_top.sv
`timescale 1ns/1ps
module tmr_top (
  input  wire logic       MCLK,                   // Oscillator clock
  input  wire logic       RST_B,                  // Asynchronous reset, active low
  input  wire logic       MC_STB,                 // Machine-cycle strobe from the core
  input  wire logic [7:0] SFR_ADDR,               // Register address
  input  wire logic       SFR_WR,                 // Register write strobe
  input  wire logic [7:0] SFR_WDATA,              // Register write data
  output logic      [7:0] SFR_RDATA,              // Registered read data
  input  wire logic       COUNT_PIN_ZERO,         // External count input, channel 0
  input  wire logic       COUNT_PIN_ONE,          // External count input, channel 1
  input  wire logic       EXT_INTERRUPT_PIN_ZERO_B, // External interrupt 0, active low
  input  wire logic       EXT_INTERRUPT_PIN_ONE_B,  // External interrupt 1, active low
  input  wire logic       ACK_OVERFLOW_ZERO,      // Core vectors to channel 0 routine
  input  wire logic       ACK_OVERFLOW_ONE,       // Core vectors to channel 1 routine
  input  wire logic       ACK_EXT_IRQ_ZERO,       // Core processes external interrupt 0
  input  wire logic       ACK_EXT_IRQ_ONE,        // Core processes external interrupt 1
  output logic            OVERFLOW_FLAG_ZERO,     // overflow_flag_zero
  output logic            OVERFLOW_FLAG_ONE,      // overflow_flag_one
  output logic            EXT_IRQ_FLAG_ZERO,      // ext_irq_flag_zero
  output logic            EXT_IRQ_FLAG_ONE        // ext_irq_flag_one
);
  import tmr_pkg::*;

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [7:0]  timer_mode_select;          // timer_mode_select contents
  logic [1:0]  tf;            // Overflow flags
  logic [1:0]  tr;            // Run bits
  logic [1:0]  ie;            // External interrupt flags
  logic [1:0]  it;            // External interrupt type bits
  logic [7:0]  timer_control_flags;          // timer_control_flags as read
  logic [1:0]  gate_en;       // Gating bits
  logic [1:0]  cnt_sel;       // Counter select bits
  tmr_mode_t   mode [2];      // Mode per channel
  logic [1:0]  cnt_pin;       // Count pins by channel
  logic [1:0]  int_pin_b;     // Interrupt pins by channel, active low
  logic [1:0]  cnt_smp;       // Count pin samples
  logic [1:0]  cnt_fall;      // Count pin falling edge pending
  logic [1:0]  int_smp;       // Interrupt pin samples
  logic [1:0]  int_fall;      // Interrupt pin falling edge pending
  logic [1:0]  run;           // Channel enabled by run and gate
  logic [1:0]  evt;           // Count source event
  logic [1:0]  count_req;     // Counting step for the channel
  logic [1:0]  tf_set;        // Overflow flag set requests
  logic [1:0]  tf_ack;        // Overflow flag hardware clears
  logic [1:0]  ie_set;        // External flag set requests
  logic [1:0]  ie_ack;        // External flag hardware clears
  logic        wr_timer_control_flags;       // Software write of timer_control_flags
  logic        wr_timer_mode_select;       // Software write of timer_mode_select
  logic        split0;        // Channel 0 in split mode
  logic [7:0]  next_rdata;    // Read data selected this cycle

  tmr_chan_if ch_if [2] ();   // One carrier per channel

  assign cnt_pin   = {COUNT_PIN_ONE, COUNT_PIN_ZERO};
  assign int_pin_b = {EXT_INTERRUPT_PIN_ONE_B, EXT_INTERRUPT_PIN_ZERO_B};
  assign tf_ack    = {ACK_OVERFLOW_ONE, ACK_OVERFLOW_ZERO};
  assign ie_ack    = {ACK_EXT_IRQ_ONE, ACK_EXT_IRQ_ZERO};
  assign wr_timer_control_flags   = SFR_WR & (SFR_ADDR == ADDR_CONTROL);
  assign wr_timer_mode_select   = SFR_WR & (SFR_ADDR == ADDR_MODE);
  assign split0    = (mode[0] == MODE_SPLIT);

  // ****************************************************************
  // Mode register
  // ****************************************************************

  // Plain read/write byte, cleared by reset
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      timer_mode_select <= MODE_RESET;
    end else if (wr_timer_mode_select) begin
      timer_mode_select <= SFR_WDATA;
    end
  end

  // ****************************************************************
  // Per-channel control, sampling and flags
  // ****************************************************************
  for (genvar i = 0; i < 2; i++) begin : g_ch
    localparam int B = i * TIMER_MODE_SELECT_NIB_W;
    localparam logic [7:0] LO_ADDR = (i == 0) ? ADDR_CNT0_LO : ADDR_CNT1_LO;
    localparam logic [7:0] HI_ADDR = (i == 0) ? ADDR_CNT0_HI : ADDR_CNT1_HI;

    // Nibble fields of the mode register
    assign gate_en[i] = timer_mode_select[B + TIMER_MODE_SELECT_GATE_BIT];
    assign cnt_sel[i] = timer_mode_select[B + TIMER_MODE_SELECT_CT_BIT];
    assign mode[i]    = tmr_mode_t'(timer_mode_select[B + TIMER_MODE_SELECT_MODE_LSB +: 2]);

    // Count pin sampled once per machine cycle
    tmr_edge_smp u_cnt_smp (
      .clk   (MCLK),
      .rst_b (RST_B),
      .stb   (MC_STB),
      .pin   (cnt_pin[i]),
      .smp   (cnt_smp[i]),
      .fall  (cnt_fall[i])
    );

    // Interrupt pin sampled once per machine cycle
    tmr_edge_smp u_int_smp (
      .clk   (MCLK),
      .rst_b (RST_B),
      .stb   (MC_STB),
      .pin   (int_pin_b[i]),
      .smp   (int_smp[i]),
      .fall  (int_fall[i])
    );

    // Gating looks at the pin level directly, pins being synchronous
    assign run[i] = tr[i] & (~gate_en[i] | int_pin_b[i]);

    // Edge pending is held until the next strobe, one machine cycle late
    assign evt[i] = cnt_sel[i] ? cnt_fall[i] : 1'b1;

    // Every step waits for the core strobe
    assign count_req[i] = MC_STB & run[i] & evt[i];

    // Level mode keeps setting while low; edge mode once per fall
    assign ie_set[i] = MC_STB & (it[i] ? int_fall[i] : ~int_smp[i]);

    // Count byte loads from software
    assign ch_if[i].mode  = mode[i];
    assign ch_if[i].wdata = SFR_WDATA;
    assign ch_if[i].wr_lo = SFR_WR & (SFR_ADDR == LO_ADDR);
    assign ch_if[i].wr_hi = SFR_WR & (SFR_ADDR == HI_ADDR);

    tmr_chan u_chan (
      .clk   (MCLK),
      .rst_b (RST_B),
      .bus   (ch_if[i])
    );

    // Overflow flag: a set in the same cycle beats any clear
    always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
        tf[i] <= CONTROL_RESET[TIMER_CONTROL_FLAGS_TF[i]];
      end else if (tf_set[i]) begin
        tf[i] <= 1'b1;
      end else if (wr_timer_control_flags) begin
        tf[i] <= SFR_WDATA[TIMER_CONTROL_FLAGS_TF[i]];
      end else if (tf_ack[i]) begin
        tf[i] <= 1'b0;
      end
    end

    // External interrupt flag: a set in the same cycle beats any clear
    always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
        ie[i] <= CONTROL_RESET[TIMER_CONTROL_FLAGS_IE[i]];
      end else if (ie_set[i]) begin
        ie[i] <= 1'b1;
      end else if (wr_timer_control_flags) begin
        ie[i] <= SFR_WDATA[TIMER_CONTROL_FLAGS_IE[i]];
      end else if (ie_ack[i]) begin
        ie[i] <= 1'b0;
      end
    end

    // Run and type bits are software only
    always_ff @(posedge MCLK or negedge RST_B) begin
      if (!RST_B) begin
        tr[i] <= CONTROL_RESET[TIMER_CONTROL_FLAGS_TR[i]];
        it[i] <= CONTROL_RESET[TIMER_CONTROL_FLAGS_IT[i]];
      end else if (wr_timer_control_flags) begin
        tr[i] <= SFR_WDATA[TIMER_CONTROL_FLAGS_TR[i]];
        it[i] <= SFR_WDATA[TIMER_CONTROL_FLAGS_IT[i]];
      end
    end
  end

  // ****************************************************************
  // Channel cross-connections
  // ****************************************************************

  // Channel 0 split high byte counts machine cycles under run bit one
  assign ch_if[0].inc       = count_req[0];
  assign ch_if[0].inc_split = MC_STB & tr[1];

  // Channel 1 in its own split mode is simply held
  assign ch_if[1].inc       = count_req[1] & (mode[1] != MODE_SPLIT);
  assign ch_if[1].inc_split = 1'b0;

  // With channel 0 split, its high byte owns flag one; channel 1 keeps
  // counting but can no longer raise it, so it is only good without interrupt
  assign tf_set[0] = ch_if[0].ovf;
  assign tf_set[1] = split0 ? ch_if[0].ovf_split : ch_if[1].ovf;

  // ****************************************************************
  // Register read-back and outputs
  // ****************************************************************

  // Assemble the control byte from its flops
  always_comb begin
    timer_control_flags = CONTROL_RESET;
    for (int k = 0; k < 2; k++) begin
      timer_control_flags[TIMER_CONTROL_FLAGS_TF[k]] = tf[k];
      timer_control_flags[TIMER_CONTROL_FLAGS_TR[k]] = tr[k];
      timer_control_flags[TIMER_CONTROL_FLAGS_IE[k]] = ie[k];
      timer_control_flags[TIMER_CONTROL_FLAGS_IT[k]] = it[k];
    end
  end

  // Unmapped addresses read as zero
  always_comb begin
    unique case (SFR_ADDR)
      ADDR_CONTROL: next_rdata = timer_control_flags;
      ADDR_MODE:    next_rdata = timer_mode_select;
      ADDR_CNT0_LO: next_rdata = ch_if[0].lo;
      ADDR_CNT1_LO: next_rdata = ch_if[1].lo;
      ADDR_CNT0_HI: next_rdata = ch_if[0].hi;
      ADDR_CNT1_HI: next_rdata = ch_if[1].hi;
      default:      next_rdata = 8'h00;
    endcase
  end

  // Read data follows the address one cycle later
  always_ff @(posedge MCLK or negedge RST_B) begin
    if (!RST_B) begin
      SFR_RDATA <= 8'h00;
    end else begin
      SFR_RDATA <= next_rdata;
    end
  end

  assign OVERFLOW_FLAG_ZERO = tf[0];
  assign OVERFLOW_FLAG_ONE  = tf[1];
  assign EXT_IRQ_FLAG_ZERO  = ie[0];
  assign EXT_IRQ_FLAG_ONE   = ie[1];

  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge MCLK); endclocking
  default disable iff (!RST_B);

  AST_TIMER_STEP: assert property (
    (mode[0] == MODE_WIDE) && !cnt_sel[0] && run[0] && MC_STB
      && !ch_if[0].wr_lo && !ch_if[0].wr_hi
    |=> {ch_if[0].hi, ch_if[0].lo} == $past({ch_if[0].hi, ch_if[0].lo}) + 16'h0001)
    else $error("Timer did not advance on a machine cycle");

  AST_NO_STROBE_HOLD: assert property (
    !MC_STB && !SFR_WR |=> $stable(ch_if[0].lo) && $stable(ch_if[1].lo))
    else $error("Count moved without a machine-cycle strobe");

  // A high-then-low sample leaves the step pending until the next strobe
  AST_EDGE_LAND: assert property (
    MC_STB && cnt_smp[0] && !cnt_pin[0] |=> cnt_fall[0])
    else $error("Sampled fall not held for the next machine cycle");

  AST_COUNT_NEEDS_EDGE: assert property (
    (mode[0] == MODE_WIDE) && cnt_sel[0] && !cnt_fall[0]
      && !ch_if[0].wr_lo && !ch_if[0].wr_hi
    |=> $stable(ch_if[0].lo))
    else $error("Counter moved without a pin edge");

  AST_GATE_BLOCK: assert property (
    gate_en[0] && !EXT_INTERRUPT_PIN_ZERO_B |-> !count_req[0])
    else $error("Gated channel counted with interrupt pin low");

  AST_RELOAD: assert property (
    (mode[1] == MODE_RELOAD) && ch_if[1].ovf && !ch_if[1].wr_lo && !ch_if[1].wr_hi
    |=> ch_if[1].lo == $past(ch_if[1].hi) && $stable(ch_if[1].hi))
    else $error("Reload value or high byte wrong");

  AST_PRESCALE: assert property (
    (mode[0] == MODE_PRESCALE) && ch_if[0].inc && ch_if[0].lo[4:0] != PRE_MAX
      && !ch_if[0].wr_hi
    |=> $stable(ch_if[0].hi))
    else $error("High byte moved before prescaler wrapped");

  AST_CHAN1_HOLD: assert property (
    (mode[1] == MODE_SPLIT) && !ch_if[1].wr_lo && !ch_if[1].wr_hi
    |=> $stable(ch_if[1].lo) && $stable(ch_if[1].hi))
    else $error("Stopped channel changed its count");

  AST_SPLIT_HI: assert property (
    split0 && MC_STB && tr[1] && !ch_if[0].wr_hi
    |=> ch_if[0].hi == $past(ch_if[0].hi) + 8'h01)
    else $error("Split high byte did not count");

  AST_FLAG_SET: assert property (
    tf_set[1] |=> tf[1])
    else $error("Overflow did not raise its flag");

  AST_LEVEL_IRQ: assert property (
    !it[0] && MC_STB && !int_smp[0] |=> ie[0] [*1] ##1 1'b1)
    else $error("Low level did not set external flag");

  // Split mode excluded: there the high byte runs on run bit one
  AST_RUN_OFF_HOLD: assert property (
    !tr[0] && !split0 && !ch_if[0].wr_lo && !ch_if[0].wr_hi
    |=> $stable(ch_if[0].lo) && $stable(ch_if[0].hi))
    else $error("Channel counted with its run bit clear");

  // Last step of the full cascade must raise the flag
  AST_WIDE_OVF: assert property (
    (mode[0] == MODE_WIDE) && ch_if[0].inc && ({ch_if[0].hi, ch_if[0].lo} == WIDE_MAX)
    |=> tf[0])
    else $error("Cascade rollover did not set overflow flag");

  // Edge mode: a held low level alone never raises the flag again
  AST_EDGE_IRQ: assert property (
    it[0] && !int_fall[0] && !ie[0] && !wr_timer_control_flags
    |=> !ie[0])
    else $error("Edge-mode flag set without a falling edge");

  // Core vectoring clears the flag when nothing sets it
  AST_FLAG_ACK: assert property (
    tf_ack[0] && !tf_set[0] && !wr_timer_control_flags
    |=> !tf[0])
    else $error("Overflow flag not cleared by vectoring");

  // Switching the channel on leaves the count bytes alone
  AST_RUN_KEEPS: assert property (
    wr_timer_control_flags && SFR_WDATA[TIMER_CONTROL_FLAGS_TR[0]] && !tr[0] && !split0
    |=> $stable(ch_if[0].lo) && $stable(ch_if[0].hi))
    else $error("Setting the run bit changed the count");

  COV_WIDE_OVF: cover property (mode[0] == MODE_WIDE && tf_set[0]);
  COV_RELOAD:   cover property (mode[1] == MODE_RELOAD && ch_if[1].ovf);
  COV_SPLIT:    cover property (split0 && ch_if[0].ovf_split);
  COV_EDGE_CNT: cover property (cnt_sel[0] && count_req[0]);

endmodule // tmr_top

// ===== tmr_pins_model.sv
`timescale 1ns/1ps
// ****************************************************************
// Core strobe and external count pin source
// ****************************************************************
module tmr_pins_model (
  input  wire logic clk,    // Oscillator clock
  input  wire logic rst_b,  // Reset, active low
  input  wire logic want0,  // Requested count_pin_zero level
  input  wire logic want1,  // Requested count_pin_one level
  output logic      mc_stb, // Machine-cycle strobe
  output logic      pin0,   // count_pin_zero
  output logic      pin1    // count_pin_one
);
  logic [2:0] phase;        // Period inside the machine cycle

  // One strobe every six periods, moved just after the edge
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      phase  <= 3'h0;
      mc_stb <= 1'b0;
    end else begin
      phase  <= #1 (phase == 3'h5) ? 3'h0 : phase + 3'h1;
      mc_stb <= #1 (phase == 3'h5);
    end
  end

  // Levels change only at a strobe, so each is held a full machine cycle
  always @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pin0 <= 1'b1;
      pin1 <= 1'b1;
    end else if (mc_stb) begin
      pin0 <= #1 want0;
      pin1 <= #1 want1;
    end
  end
endmodule // tmr_pins_model

// ===== tb_dual_timer_counter_8051_style.sv
`timescale 1ns/1ps
module tb_dual_timer_counter_8051_style;
  import tmr_pkg::*;
  // ****************************************************************
  // Stimulus and observed signals
  // ****************************************************************
  logic       mclk = 1'b0, rst_b = 1'b0, sfr_wr = 1'b0;  // Clock, reset, strobe
  logic       want0 = 1'b1, int0_b = 1'b1, int1_b = 1'b1; // Pin requests
  logic       ack_ov0 = 1'b0, ack_ex0 = 1'b0;            // Core acknowledges
  logic [7:0] sfr_addr = 8'h00, sfr_wdata = 8'h00;       // Register bus
  logic [7:0] rdata;                                     // Read data
  logic       mc_stb, pin0, pin1, ovf0, ovf1, ext0, ext1; // Design pins
  int         num_errors = 0, num_checks = 0, cycles = 0; // Counters
  always #4 mclk = ~mclk;
  tmr_pins_model i_tmr_pins_model (.clk(mclk), .rst_b(rst_b), .want0(want0), .want1(1'b1),
    .mc_stb(mc_stb), .pin0(pin0), .pin1(pin1));
  tmr_top i_tmr_top (.MCLK(mclk), .RST_B(rst_b), .MC_STB(mc_stb), .SFR_ADDR(sfr_addr),
    .SFR_WR(sfr_wr), .SFR_WDATA(sfr_wdata), .SFR_RDATA(rdata), .COUNT_PIN_ZERO(pin0),
    .COUNT_PIN_ONE(pin1), .EXT_INTERRUPT_PIN_ZERO_B(int0_b), .EXT_INTERRUPT_PIN_ONE_B(int1_b),
    .ACK_OVERFLOW_ZERO(ack_ov0), .ACK_OVERFLOW_ONE(1'b0), .ACK_EXT_IRQ_ZERO(ack_ex0),
    .ACK_EXT_IRQ_ONE(1'b0), .OVERFLOW_FLAG_ZERO(ovf0), .OVERFLOW_FLAG_ONE(ovf1),
    .EXT_IRQ_FLAG_ZERO(ext0), .EXT_IRQ_FLAG_ONE(ext1));
  // ****************************************************************
  // Shared tasks
  // ****************************************************************
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    num_checks++;
    if (seen !== exp) begin
      num_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    tick(1);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    tick(1);
    sfr_wr = 1'b0;
  endtask
  // Read data is registered, so it shows one edge after the address
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    sfr_addr = a;
    tick(1);
    check(rdata, exp);
  endtask
  // Strobe sampled at the edge, as the design sees it
  task automatic wait_stb(input int n);
    repeat (n) begin
      @(posedge mclk);
      while (mc_stb !== 1'b1) @(posedge mclk);
    end
    #1;
  endtask
  task automatic pulse(input int n);
    repeat (n) begin
      want0 = 1'b0;
      wait_stb(2);
      want0 = 1'b1;
      wait_stb(2);
    end
  endtask
  task automatic print_verdict;
    $display("checks %0d mismatches %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // ****************************************************************
  // Scenarios
  // ****************************************************************
  task automatic t_reset;
    rd(ADDR_CONTROL, CONTROL_RESET);
    rd(ADDR_MODE, MODE_RESET);
    wr(8'h90, 8'h5a);
    rd(8'h90, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_wide;
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CNT0_LO, 8'hfe);
    wr(ADDR_CNT0_HI, 8'hff);
    wr(ADDR_CONTROL, 8'h10);
    wait_stb(2);
    tick(2);
    check({7'h00, ovf0}, 8'h01);
    wr(ADDR_CONTROL, 8'h20);
    rd(ADDR_CNT0_LO, 8'h00);
    rd(ADDR_CNT0_HI, 8'h00);
    ack_ov0 = 1'b1;
    tick(1);
    ack_ov0 = 1'b0;
    rd(ADDR_CONTROL, 8'h00);
    $display("test wide done");
  endtask
  task automatic t_reload;
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_CNT1_LO, 8'hff);
    wr(ADDR_CNT1_HI, 8'ha5);
    wr(ADDR_CONTROL, 8'h40);
    wait_stb(1);
    tick(2);
    check({7'h00, ovf1}, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    check({7'h00, ovf1}, 8'h00);
    rd(ADDR_CNT1_LO, 8'ha5);
    rd(ADDR_CNT1_HI, 8'ha5);
    $display("test reload done");
  endtask
  task automatic t_prescale;
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CNT0_LO, 8'h1e);
    wr(ADDR_CNT0_HI, 8'h07);
    wr(ADDR_CONTROL, 8'h10);
    wait_stb(2);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CNT0_HI, 8'h08);
    rd(ADDR_CNT0_LO, 8'h00);
    $display("test prescale done");
  endtask
  // Gated counter: falls while the interrupt pin is low must be lost
  task automatic t_gate;
    wr(ADDR_MODE, 8'h0d);
    wr(ADDR_CNT0_LO, 8'h00);
    wr(ADDR_CNT0_HI, 8'h00);
    int0_b = 1'b0;
    wr(ADDR_CONTROL, 8'h10);
    pulse(2);
    rd(ADDR_CNT0_LO, 8'h00);
    int0_b = 1'b1;
    pulse(3);
    rd(ADDR_CNT0_LO, 8'h03);
    $display("test gate done");
  endtask
  task automatic t_extirq;
    wr(ADDR_CONTROL, 8'h01);
    int0_b = 1'b0;
    int1_b = 1'b0;
    wait_stb(3);
    check({6'h00, ext1, ext0}, 8'h03);
    ack_ex0 = 1'b1;
    tick(1);
    ack_ex0 = 1'b0;
    wait_stb(2);
    check({6'h00, ext1, ext0}, 8'h02);
    wr(ADDR_CONTROL, 8'h00);
    wait_stb(2);
    check({6'h00, ext1, ext0}, 8'h03);
    int0_b = 1'b1;
    int1_b = 1'b1;
    $display("test extirq done");
  endtask
  // Channel 0 split, channel 1 parked in its stop mode
  task automatic t_split;
    wr(ADDR_MODE, 8'h33);
    wr(ADDR_CNT0_HI, 8'hff);
    wr(ADDR_CONTROL, 8'h40);
    wait_stb(1);
    tick(2);
    check({7'h00, ovf1}, 8'h01);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_CNT0_HI, 8'h00);
    rd(ADDR_CNT0_LO, 8'h03);
    rd(ADDR_CNT1_LO, 8'ha5);
    $display("test split done");
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge mclk) begin
    cycles++;
    if (cycles > 8000) begin
      num_errors++;
      print_verdict();
    end
  end
  initial begin
    tick(4);
    rst_b = 1'b1;
    t_reset();
    t_wide();
    t_reload();
    t_prescale();
    t_gate();
    t_extirq();
    t_split();
    print_verdict();
  end
endmodule // tb_dual_timer_counter_8051_style
